// [hdl/mtf_pkg.sv]
/*
  constants shared by the move and table fetch decode core and its memory.
  assumes a single 125 MHz clock and an avalon-mm host on the byte address.
*/
package mtf_pkg;
  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [5:0] MTF_OFF_INSTR = 6'h00;
  localparam logic [5:0] MTF_OFF_STATUS = 6'h04;
  localparam logic [5:0] MTF_OFF_PAGE = 6'h08;
  localparam logic [5:0] MTF_OFF_TBASE = 6'h0C;
  localparam logic [5:0] MTF_OFF_WAKE = 6'h10;
  localparam logic [5:0] MTF_OFF_MADDR = 6'h14;
  localparam logic [5:0] MTF_OFF_MDATA = 6'h18;
  localparam logic [5:0] MTF_OFF_TADDR = 6'h1C;
  localparam logic [5:0] MTF_OFF_TDATA = 6'h20;
  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int MTF_DW = 4;
  localparam int MTF_RAM_AW = 7;
  localparam int MTF_TAB_AW = 11;
  localparam int MTF_STAT_ZERO = 4;
  localparam int MTF_STAT_BUSY = 5;
  localparam int MTF_TBASE_HI = 4;
  // ----------------------------------------------------------------
  // opcode patterns
  // ----------------------------------------------------------------
  localparam logic [8:0] MTF_OP_PAGE_RD = 9'h0BF;  // 0 1 0 1 1 1 1 1 1
  localparam logic [8:0] MTF_OP_FLAG_RD = 9'h09E;  // 0 1 0 0 1 1 1 1 0
  localparam logic [4:0] MTF_OP_WR_TO_R = 5'h0F;   // 0 1 1 1 1
  localparam logic [4:0] MTF_OP_R_TO_WR = 5'h0D;   // 0 1 1 0 1
  localparam logic [8:0] MTF_OP_TAB_R = 9'h132;    // 1 0 0 1 1 0 0 1 0
  localparam logic [4:0] MTF_OP_TAB_WR = 5'h15;    // 1 0 1 0 1
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] MTF_RST_NIB = 4'h0;
  localparam logic [15:0] MTF_RST_INSTR = 16'h0000;
  localparam logic [6:0] MTF_RST_ADDR = 7'h00;
  localparam logic [10:0] MTF_RST_TADDR = 11'h000;
  // core states, gray along idle-load-exec-table
  typedef enum logic [1:0] {
    MTF_IDLE = 2'b00,
    MTF_LOAD = 2'b01,
    MTF_EXEC = 2'b11,
    MTF_TABLE = 2'b10
  } mtf_state_t;
endpackage

// [hdl/mtf_mem.sv]
/*
  small synchronous memory, one write and one read port, registered read.
  assumes writer and reader share clk; the array itself has no reset.
*/
module mtf_mem #(
  parameter int AW = 7,
  parameter int DW = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // write port; contents are undefined until software fills them
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // registered read: data of the address seen one edge earlier
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end
endmodule // mtf_mem

// [hdl/mtf_core.sv]
/*
  move and table fetch decode core with its data memory and table memory.
  assumes an avalon-mm master with waitrequest on the byte address, and
  wake port pins that are asynchronous to clk.
*/
// How it works
// [RQ1] page read copies page_select to accumulator and memory, sets zero_flag
// [RQ2] pattern 010011110 copies port_change_flags to accumulator and memory
// [RQ3] each wake port pin has a flag set to 1 on change, else 0
// [RQ4] prefix 01111 copies a working register to accumulator and memory
// [RQ5] prefix 01101 copies memory to a working register and accumulator
// [RQ6] table fetch 10011001 0 writes a table word to memory, two cycles
// [RQ7] table address is (high base*100H + low base)*10H + accumulator; the code keeps only its low 11 bits, so high base drops out
// [RQ8] prefix 10101 fetches immediate*10H + accumulator into working register
// [RQ9] memory moves address page_select low bits*10H + address field
// [RQ10] all-zero word is a no-op; zero_flag set only for zero result
// [RQ11] table fetch destination follows the opcode field kind
module mtf_core
  import mtf_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [3:0] wake_input_port
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mtf_state_t state_q, state_d;
  logic [15:0] instr_q;
  logic [3:0] acc_q, acc_d;
  logic zero_flag_q, zero_flag_d;
  logic [3:0] page_select_q;
  logic [3:0] table_base_high_q;
  logic [3:0] table_base_low_q;
  logic [3:0] port_change_flags_q;
  logic [6:0] mem_addr_q;
  logic [10:0] tab_addr_q;
  logic rd_wait_q;
  logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire busy = (state_q != MTF_IDLE);
  wire any_lane = |avs_byteenable;
  // reads wait one cycle so the registered memory output has settled;
  // writes stall while an instruction is in flight
  assign avs_waitrequest = avs_read ? !rd_wait_q : (avs_write & busy);
  wire wr_go = avs_write & !busy & any_lane;
  wire wr_instr = wr_go & (avs_address == MTF_OFF_INSTR);
  wire wr_page = wr_go & (avs_address == MTF_OFF_PAGE);
  wire wr_tbase = wr_go & (avs_address == MTF_OFF_TBASE);
  wire wr_wake = wr_go & (avs_address == MTF_OFF_WAKE);
  wire wr_maddr = wr_go & (avs_address == MTF_OFF_MADDR);
  wire wr_mdata = wr_go & (avs_address == MTF_OFF_MDATA);
  wire wr_taddr = wr_go & (avs_address == MTF_OFF_TADDR);
  wire wr_tdata = wr_go & (avs_address == MTF_OFF_TDATA);
  wire [3:0] wake_clear = wr_wake ? avs_writedata[3:0] : 4'h0;

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  wire op_page_rd = (instr_q[15:7] == MTF_OP_PAGE_RD);   // RQ1
  wire op_flag_rd = (instr_q[15:7] == MTF_OP_FLAG_RD);   // RQ2
  wire op_wr_to_r = (instr_q[15:11] == MTF_OP_WR_TO_R);  // RQ4
  wire op_r_to_wr = (instr_q[15:11] == MTF_OP_R_TO_WR);  // RQ5
  wire op_tab_r = (instr_q[15:7] == MTF_OP_TAB_R);       // RQ6
  wire op_tab_wr = (instr_q[15:11] == MTF_OP_TAB_WR);    // RQ8
  wire op_move = op_page_rd | op_flag_rd | op_wr_to_r | op_r_to_wr;
  wire op_table = op_tab_r | op_tab_wr;
  // anything else, the all-zero word included, falls through untouched
  wire [3:0] wr_index = instr_q[10:7];
  // page-relative address wraps within the 128-word memory
  wire [6:0] page_addr = {page_select_q[2:0], 4'h0} + instr_q[6:0]; // RQ9

  // table addresses; upper bits beyond the table size are dropped
  wire [19:0] tab_base_sum = {8'h00, table_base_high_q, 8'h00}
    + {16'h0000, table_base_low_q};
  wire [19:0] tab_reg_full = {tab_base_sum[15:0], 4'h0}
    + {16'h0000, acc_q};
  wire [10:0] tab_reg_addr = tab_reg_full[10:0];              // RQ7
  wire [10:0] tab_imm_addr = {instr_q[6:0], 4'h0} + {7'h00, acc_q}; // RQ8
  wire [10:0] tab_rd_addr = op_tab_r ? tab_reg_addr : tab_imm_addr;

  // ----------------------------------------------------------------
  // memories
  // ----------------------------------------------------------------
  wire [3:0] ram_rdata;
  wire [3:0] tab_rdata;
  // working registers are the first 16 words of data memory
  wire [6:0] wr_abs = {3'h0, wr_index};
  wire [6:0] core_rd_addr = op_wr_to_r ? wr_abs : page_addr;
  wire [6:0] ram_rd_addr = busy ? core_rd_addr : mem_addr_q;
  wire [3:0] move_value = op_page_rd ? page_select_q
    : op_flag_rd ? port_change_flags_q : ram_rdata;
  wire core_move_wr = (state_q == MTF_EXEC) & op_move;
  wire core_tab_wr = (state_q == MTF_TABLE) & op_table;
  // table result goes where the opcode's field kind points
  wire [6:0] tab_dest = op_tab_r ? page_addr : wr_abs; // RQ11
  wire [6:0] move_dest = op_r_to_wr ? wr_abs : page_addr; // RQ5
  wire ram_we = core_move_wr | core_tab_wr | wr_mdata;
  wire [6:0] ram_wa = core_move_wr ? move_dest
    : core_tab_wr ? tab_dest : mem_addr_q;
  wire [3:0] ram_wd = core_move_wr ? move_value
    : core_tab_wr ? tab_rdata : avs_writedata[3:0];

  mtf_mem #(.AW(MTF_RAM_AW), .DW(MTF_DW)) u_ram (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(ram_we),
    .wr_addr(ram_wa),
    .wr_data(ram_wd),
    .rd_addr(ram_rd_addr),
    .rd_data(ram_rdata)
  );

  mtf_mem #(.AW(MTF_TAB_AW), .DW(MTF_DW)) u_table (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(wr_tdata),
    .wr_addr(tab_addr_q),
    .wr_data(avs_writedata[3:0]),
    .rd_addr(tab_rd_addr),
    .rd_data(tab_rdata)
  );

  // ----------------------------------------------------------------
  // sequencing: load launches the memory read, exec is the move cycle,
  // table is the second cycle of a fetch
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      MTF_IDLE: state_d = wr_instr ? MTF_LOAD : MTF_IDLE;
      MTF_LOAD: state_d = MTF_EXEC;
      MTF_EXEC: state_d = op_table ? MTF_TABLE : MTF_IDLE; // RQ6 RQ8
      MTF_TABLE: state_d = MTF_IDLE;
      default: state_d = MTF_IDLE;
    endcase
  end

  // accumulator and zero flag follow every move, nothing else
  always_comb begin
    acc_d = acc_q;
    zero_flag_d = zero_flag_q;
    if (core_move_wr) begin
      acc_d = move_value;                    // RQ1 RQ2 RQ4 RQ5
      zero_flag_d = (move_value == 4'h0);    // RQ10
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= MTF_IDLE;
      acc_q <= MTF_RST_NIB;
      zero_flag_q <= 1'b0;
      instr_q <= MTF_RST_INSTR;
    end else begin
      state_q <= state_d;
      acc_q <= acc_d;
      zero_flag_q <= zero_flag_d;
      if (wr_instr) instr_q <= avs_writedata[15:0];
    end
  end

  // software-written configuration
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      page_select_q <= MTF_RST_NIB;
      table_base_high_q <= MTF_RST_NIB;
      table_base_low_q <= MTF_RST_NIB;
      mem_addr_q <= MTF_RST_ADDR;
      tab_addr_q <= MTF_RST_TADDR;
      rd_wait_q <= 1'b0;
    end else begin
      if (wr_page) page_select_q <= avs_writedata[3:0];
      if (wr_tbase) table_base_low_q <= avs_writedata[3:0];
      if (wr_tbase) table_base_high_q <= avs_writedata[7:4];
      if (wr_maddr) mem_addr_q <= avs_writedata[6:0];
      if (wr_taddr) tab_addr_q <= avs_writedata[10:0];
      rd_wait_q <= avs_read & !rd_wait_q;
    end
  end

  // ----------------------------------------------------------------
  // wake port change flags
  // ----------------------------------------------------------------
  // two flops before any logic; the third stage only feeds the edge test
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_q <= MTF_RST_NIB;
      pin_s2_q <= MTF_RST_NIB;
      pin_s3_q <= MTF_RST_NIB;
    end else begin
      pin_s1_q <= wake_input_port;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_flag
      // a change in the clearing cycle survives: set beats clear
      wire changed = pin_s2_q[gi] ^ pin_s3_q[gi];
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          port_change_flags_q[gi] <= 1'b0;
        end else if (changed) begin
          port_change_flags_q[gi] <= 1'b1;  // RQ3
        end else if (wake_clear[gi]) begin
          port_change_flags_q[gi] <= 1'b0;  // RQ3
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire [31:0] stat_word = {26'h0, busy, zero_flag_q, acc_q};
  always_comb begin
    case (avs_address)
      MTF_OFF_INSTR: avs_readdata = {16'h0000, instr_q};
      MTF_OFF_STATUS: avs_readdata = stat_word;
      MTF_OFF_PAGE: avs_readdata = {28'h0, page_select_q};
      MTF_OFF_TBASE:
        avs_readdata = {24'h0, table_base_high_q, table_base_low_q};
      MTF_OFF_WAKE: avs_readdata = {28'h0, port_change_flags_q};
      MTF_OFF_MADDR: avs_readdata = {25'h0, mem_addr_q};
      MTF_OFF_MDATA: avs_readdata = {28'h0, ram_rdata};
      MTF_OFF_TADDR: avs_readdata = {21'h0, tab_addr_q};
      default: avs_readdata = 32'h0000_0000;
    endcase
  end
endmodule // mtf_core

// [tb/mtf_core_sva.sv]
/*
  bus-port assertions for the move and table fetch decode core.
  assumes an avalon master that holds read until waitrequest falls.
*/
module mtf_core_sva
  import mtf_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [3:0] wake_input_port
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic instr_wr = avs_write && !avs_waitrequest &&
    avs_address == MTF_OFF_INSTR;
  logic [2:0] idle_cnt_q;
  // saturates at 7, well past the longest busy span
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) idle_cnt_q <= 3'h7;
    else if (instr_wr) idle_cnt_q <= 3'h0;
    else if (idle_cnt_q != 3'h7) idle_cnt_q <= idle_cnt_q + 3'h1;
  sequence s_rd_wait;
    avs_read && avs_waitrequest;
  endsequence
  sequence s_rd_done;
    avs_read && !avs_waitrequest;
  endsequence
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  AST_RD_FIRST: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read answered without its wait cycle");
  AST_RD_ONE_WAIT: assert property
    (s_rd_wait ##1 avs_read |-> !avs_waitrequest)
    else $error("read kept waiting past one cycle");
  AST_UNMAPPED: assert property (s_rd_done ##0
    (avs_address > MTF_OFF_TDATA) |-> avs_readdata == 32'h0)
    else $error("unmapped offset read nonzero");
  AST_TDATA_ZERO: assert property (s_rd_done ##0
    (avs_address == MTF_OFF_TDATA) |-> avs_readdata == 32'h0)
    else $error("table data port read nonzero");
  AST_STATUS_HIGH: assert property (s_rd_done ##0
    (avs_address == MTF_OFF_STATUS) |-> avs_readdata[31:6] == 26'h0)
    else $error("status upper bits nonzero");
  AST_WAKE_HIGH: assert property (s_rd_done ##0
    (avs_address == MTF_OFF_WAKE) |-> avs_readdata[31:4] == 28'h0)
    else $error("change flag upper bits nonzero");
  AST_BUSY_STALL: assert property
    (instr_wr ##2 avs_write |-> avs_waitrequest)
    else $error("write accepted while instruction executes");
  AST_IDLE_NO_WAIT: assert property
    (avs_write && idle_cnt_q == 3'h7 |-> !avs_waitrequest)
    else $error("write stalled long after execution ended");
endmodule // mtf_core_sva

bind mtf_core mtf_core_sva u_sva (
  .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .wake_input_port(wake_input_port)
);

// [tb/test_move_and_table_fetch_decode.sv]
/*
  self-checking bench for the decode core through its avalon port.
  assumes the checker is bound in from its own file.
*/
module test_move_and_table_fetch_decode import mtf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;  // all lanes, lane logic untested
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] wake_input_port = 4'h0;
  logic [31:0] rdata;
  int failures = 0;
  int total_checks = 0;
  initial forever #4 clk = ~clk;
  mtf_core dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .wake_input_port(wake_input_port));
  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one access; a gap cycle follows so strobes never re-rise at once
  task automatic acc(input logic we, input logic [5:0] addr,
    input logic [31:0] data);
    int n;
    logic wait_seen;
    n = 0;
    avs_read <= !we;
    avs_write <= we;
    avs_address <= addr;
    avs_writedata <= data;
    // look mid-cycle, where the answer has settled for the coming edge;
    // sampling right at the edge would race the design's own updates
    do begin
      @(negedge clk);
      wait_seen = avs_waitrequest;
      rdata = avs_readdata;
      n++;
      @(posedge clk);
    end while (wait_seen && n < 50);
    if (wait_seen) failures++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input string what, input logic [5:0] addr,
    input logic [31:0] exp);
    acc(1'b0, addr, 32'h0);
    chk(what, exp, rdata);
  endtask
  // address register sits one word below its data port
  task automatic poke(input logic [5:0] aoff, input logic [31:0] a,
    input logic [31:0] d);
    acc(1'b1, aoff, a);
    acc(1'b1, aoff + 6'h04, d);
  endtask
  // the address write stalls until the instruction has finished
  task automatic mv(input logic [15:0] instr, input logic [31:0] stat,
    input logic [6:0] maddr, input logic [3:0] mdat);
    acc(1'b1, MTF_OFF_INSTR, {16'h0, instr});
    acc(1'b1, MTF_OFF_MADDR, {25'h0, maddr});
    rd_chk("status", MTF_OFF_STATUS, stat);
    rd_chk("memory", MTF_OFF_MDATA, {28'h0, mdat});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd_chk("tbase", MTF_OFF_TBASE, 32'h0);
    acc(1'b1, MTF_OFF_TBASE, 32'h12);
    rd_chk("tbase", MTF_OFF_TBASE, 32'h12);
    rd_chk("flags", MTF_OFF_WAKE, 32'h0);
    wake_input_port <= 4'h5;
    repeat (6) @(posedge clk);
    rd_chk("flags", MTF_OFF_WAKE, 32'h5);
    acc(1'b1, MTF_OFF_PAGE, 32'h2);
    mv({MTF_OP_FLAG_RD, 7'h20}, 32'h05, 7'h40, 4'h5);
    acc(1'b1, MTF_OFF_WAKE, 32'hF);
    rd_chk("flags", MTF_OFF_WAKE, 32'h0);
    acc(1'b1, MTF_OFF_PAGE, 32'h3);
    mv({MTF_OP_PAGE_RD, 7'h7F}, 32'h03, 7'h2F, 4'h3);
    acc(1'b1, MTF_OFF_PAGE, 32'h8);
    mv({MTF_OP_PAGE_RD, 7'h11}, 32'h08, 7'h11, 4'h8);
    acc(1'b1, MTF_OFF_PAGE, 32'h0);
    mv({MTF_OP_PAGE_RD, 7'h12}, 32'h10, 7'h12, 4'h0);
    poke(MTF_OFF_MADDR, 32'h7, 32'h9);
    poke(MTF_OFF_MADDR, 32'h16, 32'hC);
    acc(1'b1, MTF_OFF_PAGE, 32'h1);
    mv({MTF_OP_WR_TO_R, 4'h7, 7'h05}, 32'h09, 7'h15, 4'h9);
    mv({MTF_OP_R_TO_WR, 4'h3, 7'h06}, 32'h0C, 7'h03, 4'hC);
    poke(MTF_OFF_TADDR, ((32'h1 * 32'h100 + 32'h2) * 32'h10 + 32'hC)
      % 32'h800, 32'hA);
    mv({MTF_OP_TAB_R, 7'h06}, 32'h0C, 7'h16, 4'hA);
    poke(MTF_OFF_TADDR, 32'h5 * 32'h10 + 32'hC, 32'h6);
    mv({MTF_OP_TAB_WR, 4'h4, 7'h05}, 32'h0C, 7'h04, 4'h6);
    mv(16'h0000, 32'h0C, 7'h16, 4'hA);
    rd_chk("unmapped", 6'h24, 32'h0);
    rd_chk("table port", MTF_OFF_TDATA, 32'h0);
    tally_and_finish();
  end
  // watchdog: the tests need well under a thousand cycles
  initial begin
    #20000;
    failures++;
    tally_and_finish();
  end
endmodule // test_move_and_table_fetch_decode
